/* core/dpi_ddr3_pins.sv */
module dpi_ddr3_pins
  import dpi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic byteWide,
  input wire logic cke,
  input wire dpi_cmd_s cmd,
  input wire logic odt,
  input wire logic dm,
  input wire logic [7:0] dqIn,
  input wire logic [7:0] rdData,
  output logic [7:0] dqOut,
  output logic [7:0] dqOe,
  output logic dqsOut,
  output logic dqsOe,
  output logic tdqsTerm,
  output logic odtOn,
  output dpi_pwr_e pwrState,
  output logic [NBANK-1:0] bankOpen,
  output dpi_acc_s access,
  output logic rdReq,
  output logic wrBeat,
  output logic [7:0] wrData,
  output logic [ADDR_W-1:0] mr0,
  output logic [ADDR_W-1:0] mr1,
  output logic [ADDR_W-1:0] mr2,
  output logic [ADDR_W-1:0] mr3
);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    dpi_cmd_s cmdS1;
    dpi_cmd_s cmdS2;
    logic ckeS1;
    logic ckeS2;
    logic ckeReg;
    logic odtS1;
    logic odtS2;
    logic dmS1;
    logic dmS2;
    logic [7:0] dqS1;
    logic [7:0] dqS2;
    dpi_pwr_e pwr;
    logic [NBANK-1:0] open;
    logic [NBANK-1:0][ADDR_W-1:0] rowOf;
    logic [3:0][ADDR_W-1:0] mr;
    dpi_acc_s acc;
    logic [3:0] beatCnt;
    logic rdOn;
    logic wrOn;
    logic dqs;
    logic [7:0] dqo;
    logic odtOn;
    logic rdReq;
    logic wrBeat;
    logic [7:0] wrData;
  } dpi_state_s;

  dpi_state_s st, next_st;
  logic [3:0] code;
  logic tdqsOn;

  // {cs, ras, cas, we} as one code; cs high maps to CMD_NOP
  function automatic logic [3:0] cmdCode(input dpi_cmd_s c);
    return c.csN ? CMD_NOP : {c.rasN, c.casN, c.weN} + 4'h0;
  endfunction

  // burst length from mode register and a12
  function automatic logic [3:0] burstBeats(input logic [ADDR_W-1:0] m0,
                                            input logic a12);
    logic [1:0] bl;
    bl = m0[MR0_BL_LSB+:2];
    if (bl == BL_BC4) return BEATS_BC4;
    if (bl == BL_OTF) return a12 ? BEATS_BL8 : BEATS_BC4;
    return BEATS_BL8;
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    code = cmdCode(st.cmdS2);
    tdqsOn = byteWide && st.mr[1][MR1_TDQS];
    // pins pass two flops; sampling on the rising edge of clk
    next_st.cmdS1 = cmd;
    next_st.cmdS2 = st.cmdS1;
    next_st.ckeS1 = cke;
    next_st.ckeS2 = st.ckeS1;
    next_st.odtS1 = odt;
    next_st.odtS2 = st.odtS1;
    next_st.dmS1 = dm;
    next_st.dmS2 = st.dmS1;
    next_st.dqS1 = dqIn;
    next_st.dqS2 = st.dqS1;
    next_st.ckeReg = st.ckeS2;
    next_st.rdReq = 1'b0;
    next_st.wrBeat = 1'b0;

    unique case (st.pwr)
      ST_ACTIVE: begin
        if (!st.ckeS2) begin
          if (st.open != '0) begin
            next_st.pwr = ST_PD_ACT;
          end else if (code == CMD_REF) begin
            next_st.pwr = ST_SELFREF;
          end else begin
            next_st.pwr = ST_PD_PRE;
          end
          next_st.rdOn = 1'b0;
          next_st.wrOn = 1'b0;
          next_st.dqs = 1'b0;
        end else begin
          // chip select high yields NOP, so nothing is decoded
          unique case (code)
            CMD_ACT: begin
              next_st.open[st.cmdS2.ba] = 1'b1;
              next_st.rowOf[st.cmdS2.ba] = st.cmdS2.addr;
            end
            CMD_PRE: begin
              if (st.cmdS2.addr[AP_BIT]) begin
                next_st.open = '0;
              end else begin
                next_st.open[st.cmdS2.ba] = 1'b0;
              end
            end
            CMD_MRS: begin
              next_st.mr[st.cmdS2.ba[1:0]] = st.cmdS2.addr;
            end
            CMD_RD, CMD_WR: begin
              next_st.acc.valid = 1'b1;
              next_st.acc.write = (code == CMD_WR);
              next_st.acc.bank = st.cmdS2.ba;
              next_st.acc.row = st.rowOf[st.cmdS2.ba];
              next_st.acc.col = st.cmdS2.addr[COL_W-1:0];
              next_st.acc.autoPre = st.cmdS2.addr[AP_BIT];
              next_st.acc.beats = burstBeats(st.mr[0],
                                             st.cmdS2.addr[BC_BIT]);
              next_st.beatCnt = next_st.acc.beats;
              next_st.rdOn = (code == CMD_RD);
              next_st.wrOn = (code == CMD_WR);
              next_st.rdReq = (code == CMD_RD);
              if (st.cmdS2.addr[AP_BIT]) begin
                next_st.open[st.cmdS2.ba] = 1'b0;
              end
            end
            default: begin
            end
          endcase
          // burst engine: one beat per clock, strobe toggles with read data;
          // a new read or write restarts the count, so skip the old beat
          if (st.beatCnt != 4'h0 && code != CMD_RD && code != CMD_WR) begin
            next_st.beatCnt = st.beatCnt - 4'h1;
            if (st.rdOn) begin
              next_st.dqo = rdData;
              next_st.dqs = ~st.dqs;
            end
            // masked beats skip the array unless tdqs is on in byte mode
            if (st.wrOn && !(st.dmS2 && !tdqsOn)) begin
              next_st.wrBeat = 1'b1;
              next_st.wrData = st.dqS2;
            end
            if (st.beatCnt == 4'h1) begin
              next_st.rdOn = 1'b0;
              next_st.wrOn = 1'b0;
              next_st.acc.valid = 1'b0;
            end
          end
        end
      end
      ST_PD_PRE, ST_PD_ACT: begin
        // only cke and odt observed here
        if (st.ckeS2) begin
          next_st.pwr = ST_ACTIVE;
        end
      end
      ST_SELFREF: begin
        // cke exit is asynchronous; see exit flop below
      end
    endcase

    // termination follows odt outside self refresh, unless a mode load disabled it
    if (st.pwr != ST_SELFREF) begin
      next_st.odtOn = st.odtS2 && !st.mr[1][MR1_RTT_DIS];
    end else begin
      next_st.odtOn = 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // self refresh exit seen on cke alone, clock ignored
  logic srExit;
  always_ff @(posedge cke or negedge rst_n) begin
    if (!rst_n) begin
      srExit <= 1'b0;
    end else begin
      srExit <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cmdS1.csN <= 1'b1;
      st.cmdS2.csN <= 1'b1;
      st.mr <= {4{MR_RESET}};
    end else if (st.pwr == ST_SELFREF) begin
      // clock-domain state frozen; only the async exit is watched
      if (srExit && cke) begin
        st.pwr <= ST_PD_PRE;
        st.ckeS1 <= 1'b0;
        st.ckeS2 <= 1'b0;
      end
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_comb begin
    dqOut = st.dqo;
    dqOe = {8{st.rdOn && st.beatCnt != 4'h0}}
           & (byteWide ? 8'hff : 8'h0f);
    dqsOut = st.dqs;
    dqsOe = st.rdOn;
    tdqsTerm = tdqsOn && st.odtOn;
    odtOn = st.odtOn;
    pwrState = st.pwr;
    bankOpen = st.open;
    access = st.acc;
    rdReq = st.rdReq;
    wrBeat = st.wrBeat;
    wrData = st.wrData;
    mr0 = st.mr[0];
    mr1 = st.mr[1];
    mr2 = st.mr[2];
    mr3 = st.mr[3];
  end

endmodule // dpi_ddr3_pins

/* pkg/dpi_pkg.sv */
package dpi_pkg;
  // command code {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int NBANK = 8;
  // mode register fields chosen for this model
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;
  localparam int MR1_RTT_DIS = 2;
  localparam int MR1_TDQS = 11;
  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  localparam logic [3:0] BEATS_BC4 = 4'h4;

  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_PD_PRE = 2'b01,
    ST_PD_ACT = 2'b10,
    ST_SELFREF = 2'b11
  } dpi_pwr_e;

  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [2:0] ba;
    logic [ADDR_W-1:0] addr;
  } dpi_cmd_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0] col;
    logic autoPre;
    logic [3:0] beats;
  } dpi_acc_s;
endpackage : dpi_pkg

/* test/dpi_ctl_model.sv */
module dpi_ctl_model
  import dpi_pkg::*;
(
  input wire logic clk,
  output dpi_cmd_s cmd,
  output logic dm,
  output logic [7:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // controller side of the pins
  // ----------------------------------------
  initial begin
    cmd = {4'hf, 3'h0, 14'h0000};
    dm = 1'b0;
    dqIn = 8'h5a;
  end
  // one command cycle; released pins show the inverse, not a stale copy
  task automatic issue(input logic [3:0] code, input logic [2:0] ba,
                       input logic [13:0] addr);
    @(posedge clk) #2;
    cmd = {code, ba, addr};
    @(posedge clk) #2;
    cmd = {4'hf, ~ba, ~addr};
  endtask
  // beats change just after the edge, so each edge samples at the end of its beat
  task automatic wbeats(input logic [63:0] d, input logic [7:0] m);
    for (int i = 0; i < 8; i++) begin
      dqIn = d[8*i+:8];
      dm = m[i];
      @(posedge clk) #2;
    end
    dqIn = ~dqIn;
    dm = 1'b0;
  endtask
endmodule // dpi_ctl_model

/* test/dpi_ddr3_pins_chk.sv */
module dpi_ddr3_pins_chk
  import dpi_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic byteWide,
  input wire logic cke,
  input wire dpi_cmd_s cmd,
  input wire logic [7:0] dqOe,
  input wire logic dqsOe,
  input wire logic tdqsTerm,
  input wire logic odtOn,
  input wire dpi_pwr_e pwrState,
  input wire logic [NBANK-1:0] bankOpen,
  input wire dpi_acc_s access,
  input wire logic rdReq,
  input wire logic [ADDR_W-1:0] mr0,
  input wire logic [ADDR_W-1:0] mr1
);
  // three enabled cycles are needed before a pin value reaches decode
  logic [2:0] enH;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) enH <= 3'h0;
    else enH <= {enH[1:0], clkEn && cke && pwrState == ST_ACTIVE};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_dec(logic [3:0] c);
    &enH && $past(cmd[20:17], 3) == c;
  endsequence
  a_act_open: assert property (s_dec(CMD_ACT) |->
    bankOpen[$past(cmd.ba, 3)]) else $error("activate left bank closed");
  a_pre_one: assert property (s_dec(CMD_PRE) ##0
    !$past(cmd.addr[AP_BIT], 3) |-> !bankOpen[$past(cmd.ba, 3)])
    else $error("precharge left bank open");
  a_pre_all: assert property (s_dec(CMD_PRE) ##0
    $past(cmd.addr[AP_BIT], 3) |-> bankOpen == '0)
    else $error("precharge all left a bank open");
  a_mrs_load: assert property (s_dec(CMD_MRS) ##0
    $past(cmd.ba, 3) == 3'h1 |-> mr1 == $past(cmd.addr, 3))
    else $error("mode register not loaded");
  a_cs_mask: assert property (&enH && $past(cmd.csN, 3) |->
    $stable(mr0) && $stable(mr1)) else $error("deselected command acted");
  a_rd_decode: assert property (s_dec(CMD_RD) |->
    rdReq && !access.write && access.bank == $past(cmd.ba, 3) &&
    access.col == $past(cmd.addr[COL_W-1:0], 3) &&
    access.autoPre == $past(cmd.addr[AP_BIT], 3))
    else $error("read decode wrong");
  a_chop_len: assert property (s_dec(CMD_RD) ##0 mr0[1:0] == BL_OTF |->
    access.beats == ($past(cmd.addr[BC_BIT], 3) ? BEATS_BL8 : BEATS_BC4))
    else $error("burst length wrong");
  a_nibble_dq: assert property (!byteWide |-> dqOe[7:4] == 4'h0)
    else $error("upper data driven in nibble mode");
  a_dq_read: assert property (dqOe != 8'h00 |-> dqsOe)
    else $error("data driven without strobe");
  a_tdqs_term: assert property (tdqsTerm |->
    byteWide && mr1[MR1_TDQS] && odtOn) else $error("stray tdqs");
  a_sr_hold: assert property (pwrState == ST_SELFREF && !cke |=>
    pwrState == ST_SELFREF) else $error("self refresh left early");
endmodule // dpi_ddr3_pins_chk
bind dpi_ddr3_pins dpi_ddr3_pins_chk u_chk(.clk, .rst_n, .clkEn, .byteWide,
  .cke, .cmd, .dqOe, .dqsOe, .tdqsTerm, .odtOn, .pwrState, .bankOpen,
  .access, .rdReq, .mr0, .mr1);

/* test/tb_top.sv */
module tb_top
  import dpi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, clkEn, byteWide, cke, odt, dm, tdqsTerm, odtOn, rdReq;
  logic dqsOe, wrBeat;
  logic [7:0] dqIn, rdData, dqOe, wrData, mb;
  logic [13:0] mr0, mr1, mr2, mr3, mrv [4];
  logic [9:0] col;
  logic [2:0] b;
  dpi_cmd_s cmd;
  dpi_pwr_e pwrState;
  logic [NBANK-1:0] bankOpen;
  dpi_acc_s access;
  logic [17:0] expRd[$];
  logic [7:0] expWr[$];
  logic [63:0] d;
  int errors = 0, nTests = 0, seed = 14265;
  dpi_ctl_model u_ctl(.clk, .cmd, .dm, .dqIn);
  dpi_ddr3_pins u_dut(.clk, .rst_n, .clkEn, .byteWide, .cke, .cmd, .odt,
    .dm, .dqIn, .rdData, .dqOut(), .dqOe, .dqsOut(), .dqsOe, .tdqsTerm,
    .odtOn, .pwrState, .bankOpen, .access, .rdReq, .wrBeat, .wrData, .mr0,
    .mr1, .mr2, .mr3);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) #2 rdData = $random(seed);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    #1;
    if (rdReq === 1'b1) chk("access", expRd.size() ? expRd.pop_front() : 'x,
      {access.bank, access.col, access.autoPre, access.beats});
    if (wrBeat === 1'b1)
      chk("wrData", expWr.size() ? expWr.pop_front() : 'x, wrData);
  end
  // a full run is about 125 cycles; some thirty times that means a hang
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    {clkEn, byteWide, cke, odt, rst_n} = {3'b111, 2'b00};
    repeat (12) @(posedge clk);
    #2 rst_n = 1;
    for (int i = 0; i < 4; i++) begin
      mrv[i] = $random(seed);
      u_ctl.issue(CMD_MRS, i[2:0], mrv[i]);
    end
    settle(3);
    chk("mrs", {mrv[0], mrv[1]}, {mr0, mr1});
    chk("mrs", {mrv[2], mrv[3]}, {mr2, mr3});
    u_ctl.issue(CMD_MRS, 3'h0, {12'h000, BL_OTF});
    b = $random(seed);
    u_ctl.issue(CMD_ACT | 4'h8, b, 14'h1abc);
    settle(3);
    chk("bankOpen", 0, bankOpen);
    u_ctl.issue(CMD_ACT, b, 14'h1abc);
    settle(3);
    chk("bankOpen", 1 << b, bankOpen);
    $display("test setup finished");
    for (int k = 0; k < 2; k++) begin
      col = $random(seed);
      expRd.push_back({b, col, 1'b0, k ? BEATS_BL8 : BEATS_BC4});
      u_ctl.issue(CMD_RD, b, {1'b0, k[0], 2'b00, col});
    end
    d = {$random(seed), $random(seed)};
    mb = $random(seed);
    // with the termination strobe enabled in byte mode masking is off
    for (int i = 0; i < 8; i++)
      if (!mb[i] || mrv[1][MR1_TDQS]) expWr.push_back(d[8*i+:8]);
    u_ctl.issue(CMD_WR, b, {4'h4, col});
    u_ctl.wbeats(d, mb);
    settle(12);
    $display("test burst finished");
    u_ctl.issue(CMD_ACT, b ^ 3'h1, 14'h0001);
    u_ctl.issue(CMD_PRE, b, 14'h0000);
    settle(3);
    chk("bankOpen", 1 << (b ^ 3'h1), bankOpen);
    @(posedge clk) #2 cke = 0;
    settle(5);
    chk("pwrState", ST_PD_ACT, pwrState);
    #1 cke = 1;
    settle(5);
    chk("pwrState", ST_ACTIVE, pwrState);
    u_ctl.issue(CMD_PRE, 3'h0, 14'h0400);
    settle(3);
    chk("bankOpen", 0, bankOpen);
    fork
      u_ctl.issue(CMD_REF, 3'h0, 14'h0000);
      begin
        @(posedge clk) #2 cke = 0;
      end
    join
    settle(5);
    chk("pwrState", ST_SELFREF, pwrState);
    #1 cke = 1;
    settle(1);
    chk("pwrState", ST_PD_PRE, pwrState);
    settle(5);
    chk("pwrState", ST_ACTIVE, pwrState);
    $display("test power finished");
    u_ctl.issue(CMD_MRS, 3'h1, 14'h0800);
    odt = 1;
    settle(4);
    chk("term", 2'b11, {odtOn, tdqsTerm});
    u_ctl.issue(CMD_MRS, 3'h1, 14'h0004);
    settle(4);
    chk("term", 2'b00, {odtOn, tdqsTerm});
    byteWide = 0;
    u_ctl.issue(CMD_ACT, 3'h2, 14'h0002);
    expRd.push_back({3'h2, 10'h155, 1'b1, BEATS_BL8});
    u_ctl.issue(CMD_RD, 3'h2, 14'h1555);
    settle(12);
    chk("pending", 0, expRd.size() + expWr.size());
    $display("test termination finished");
    print_verdict();
  end
endmodule // tb_top
